/* hdl/dso_map.svh */
// What this block does
// - homing_done sets on high-speed homing, normal homing or position preset done.
// - homing_done clears at power-up and whenever an operation starts with no homing or preset completion in that cycle.
// - data_number_toggle inverts at the start of a data-driven operation and on data number switch.
// - toggle, active number and done flags only meaningful in data-driven operations.
// - active_data_number shows the executing operation-data number in binary.
// - active_data_number holds its old value in operations without operation data.
// - done flags clear at start; bit sets when its selected data number completes.
// - each done flag selects a data number 0..255; bit n defaults to n.
// - zero_speed when feedback speed magnitude is at or below the range.
// - zero-speed range configurable 0..200 r/min, default 15.
// - overload_warning when output torque reaches the overload detection level.
// - stored_sequence_busy stays on for the whole stored-data operation.
// - delay_wait_busy on during drive-complete delay and dwell standby.
// - direct_buffer_writing on while direct-data buffer is being written.
// - direct_ready needs power, servo on, no stops, clear, alarm, homing, macro.
// - direct_ready off while setup tool teaches, tests, writes or resets.
// - direct_ready off while network configuration or batch memory commands run.
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH
`define DSO_ADDR_ZV_RANGE   8'h00
`define DSO_ADDR_SEL_LO     8'h04
`define DSO_ADDR_SEL_HI     8'h08
`define DSO_ADDR_STATUS     8'h0C
`define DSO_ZV_RANGE_RST    8'h0F
`define DSO_ZV_RANGE_MAX    8'hC8
`define DSO_SEL_LO_RST      32'h03020100
`define DSO_SEL_HI_RST      32'h07060504
`define DSO_HTRANS_NONSEQ_B 1
`define DSO_ST_HOME_BIT     0
`define DSO_ST_TOG_BIT      1
`define DSO_ST_ZV_BIT       2
`define DSO_ST_OL_BIT       3
`define DSO_ST_SEQ_BIT      4
`define DSO_ST_DLY_BIT      5
`define DSO_ST_BUF_BIT      6
`define DSO_ST_RDY_BIT      7
`define DSO_ST_ACT_LSB      8
`define DSO_ST_DONE_LSB     16
`endif

/* hdl/dso_pkg.sv */
package dso_pkg;
  // events and levels from the motion sequencer, same clock
  typedef struct packed {
    logic       op_start;      // any operation starts
    logic       uses_data;     // started operation uses operation data
    logic       data_switch;   // data number switched mid-operation
    logic [7:0] data_no;       // data number being started or switched to
    logic       data_complete; // one data number finished
    logic [7:0] complete_no;   // number that finished
    logic       hs_home_done;  // high-speed homing completed
    logic       home_done;     // normal homing completed
    logic       preset_done;   // position preset set coordinates
    logic       seq_running;   // stored-data operation executing
    logic       drive_delay;   // drive-complete delay running
    logic       dwell;         // dwell standby
    logic       buf_writing;   // direct-data buffer being written
  } dso_seq_t;
  // asynchronous readiness conditions, synchronised inside
  typedef struct packed {
    logic ctrl_power;
    logic main_power;
    logic servo_on_input;
    logic stop_input;
    logic stop_with_power_removal_input;
    logic deviation_clear_input;
    logic alarm;
    logic homing_running;
    logic macro_running;
    logic tool_busy;   // teaching, remote, io test, data writing, reset
    logic net_busy;    // configuration, batch init, nv or backup transfer
  } dso_ready_t;
  typedef struct packed {
    logic [7:0] data_done_flags;
    logic [7:0] active_data_number;
    logic       direct_ready;
    logic       direct_buffer_writing;
    logic       delay_wait_busy;
    logic       stored_sequence_busy;
    logic       overload_warning;
    logic       zero_speed;
    logic       data_number_toggle;
    logic       homing_done;
  } dso_status_t;
  typedef logic [7:0] dso_sel_t [8];
endpackage

/* hdl/dso_status.sv */
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`include "dso_map.svh"
module dso_status
(
  input  wire logic               clk,        // 20 MHz control clock
  input  wire logic               arst_n,     // async reset, active low
  input  wire dso_pkg::dso_seq_t   seq,        // sequencer events
  input  wire dso_pkg::dso_ready_t rdy_in,     // readiness pins
  input  wire logic signed [15:0] fb_speed,   // feedback speed, r/min
  input  wire logic [15:0]        torque,     // output torque
  input  wire logic [15:0]        ol_level,   // overload detect torque
  input  wire logic               hsel,       // ahb select
  input  wire logic [7:0]         haddr,      // ahb address
  input  wire logic [1:0]         htrans,     // ahb transfer type
  input  wire logic               hwrite,     // ahb write
  input  wire logic [2:0]         hsize,      // ahb size
  input  wire logic [31:0]        hwdata,     // ahb write data
  input  wire logic               hready,     // ahb bus ready
  output logic                    hreadyout,  // ahb slave ready
  output logic                    hresp,      // ahb response
  output logic [31:0]             hrdata,     // ahb read data
  output dso_pkg::dso_status_t    status      // status outputs
);
  import dso_pkg::*;

  // register state
  logic [7:0]  zv_range_ff, nxt_zv_range;
  logic [31:0] sel_lo_ff, nxt_sel_lo, sel_hi_ff, nxt_sel_hi;
  logic        wr_pend_ff, nxt_wr_pend;
  logic [7:0]  wr_addr_ff, nxt_wr_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic        hreadyout_ff;
  logic        hresp_ff;
  dso_status_t st_ff, nxt_st;
  dso_ready_t  rdy_s1_ff, rdy_s2_ff;
  dso_sel_t    sel;
  logic        addr_ph;
  logic [15:0] spd_mag;
  logic        ready_now;

  assign addr_ph = hsel & hready & htrans[`DSO_HTRANS_NONSEQ_B];
  assign spd_mag = fb_speed[15] ? 16'(-fb_speed) : 16'(fb_speed);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      sel[i]   = sel_lo_ff[8*i +: 8];
      sel[i+4] = sel_hi_ff[8*i +: 8];
    end
  end

  // ahb slave: zero wait, write applied in data phase
  always_comb
  begin
    nxt_wr_pend  = addr_ph & hwrite;
    nxt_wr_addr  = addr_ph ? haddr : wr_addr_ff;
    nxt_hrdata   = hrdata_ff;
    nxt_zv_range = zv_range_ff;
    nxt_sel_lo   = sel_lo_ff;
    nxt_sel_hi   = sel_hi_ff;
    if (addr_ph & ~hwrite)
    begin
      if (haddr == `DSO_ADDR_ZV_RANGE)
        nxt_hrdata = {24'h000000, zv_range_ff};
      else if (haddr == `DSO_ADDR_SEL_LO)
        nxt_hrdata = sel_lo_ff;
      else if (haddr == `DSO_ADDR_SEL_HI)
        nxt_hrdata = sel_hi_ff;
      else if (haddr == `DSO_ADDR_STATUS)
        nxt_hrdata = {8'h00, st_ff};
      else
        nxt_hrdata = 32'h00000000;
    end
    if (wr_pend_ff)
    begin
      if (wr_addr_ff == `DSO_ADDR_ZV_RANGE)
        nxt_zv_range = (hwdata[7:0] > `DSO_ZV_RANGE_MAX) ? `DSO_ZV_RANGE_MAX : hwdata[7:0];
      else if (wr_addr_ff == `DSO_ADDR_SEL_LO)
        nxt_sel_lo = hwdata;
      else if (wr_addr_ff == `DSO_ADDR_SEL_HI)
        nxt_sel_hi = hwdata;
    end
  end

  // ahb and configuration registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b0;
      hresp_ff     <= 1'b0;
      zv_range_ff  <= `DSO_ZV_RANGE_RST;
      sel_lo_ff    <= `DSO_SEL_LO_RST;
      sel_hi_ff    <= `DSO_SEL_HI_RST;
    end
    else
    begin
      wr_pend_ff   <= nxt_wr_pend;
      wr_addr_ff   <= nxt_wr_addr;
      hrdata_ff    <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      zv_range_ff  <= nxt_zv_range;
      sel_lo_ff    <= nxt_sel_lo;
      sel_hi_ff    <= nxt_sel_hi;
    end
  end
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;
  assign hrdata    = hrdata_ff;

  // two-flop synchroniser for readiness pins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdy_s1_ff <= '0;
      rdy_s2_ff <= '0;
    end
    else
    begin
      rdy_s1_ff <= rdy_in;
      rdy_s2_ff <= rdy_s1_ff;
    end
  end

  assign ready_now = rdy_s2_ff.ctrl_power & rdy_s2_ff.main_power & rdy_s2_ff.servo_on_input
                   & ~rdy_s2_ff.stop_input & ~rdy_s2_ff.stop_with_power_removal_input
                   & ~rdy_s2_ff.deviation_clear_input & ~rdy_s2_ff.alarm
                   & ~rdy_s2_ff.homing_running & ~rdy_s2_ff.macro_running
                   & ~rdy_s2_ff.tool_busy
                   & ~rdy_s2_ff.net_busy;

  // status next values
  always_comb
  begin
    nxt_st = st_ff;
    if (seq.op_start)
      nxt_st.homing_done = 1'b0;
    if (seq.hs_home_done | seq.home_done | seq.preset_done)
      nxt_st.homing_done = 1'b1;
    if ((seq.op_start & seq.uses_data) | seq.data_switch)
      nxt_st.data_number_toggle = ~st_ff.data_number_toggle;
    if ((seq.op_start & seq.uses_data) | seq.data_switch)
      nxt_st.active_data_number = seq.data_no;
    // clear at start, set on completion
    if (seq.op_start)
      nxt_st.data_done_flags = 8'h00;
    for (int i = 0; i < 8; i++)
      if (seq.data_complete && seq.complete_no == sel[i])
        nxt_st.data_done_flags[i] = 1'b1;
    nxt_st.zero_speed            = spd_mag <= {8'h00, zv_range_ff};
    nxt_st.overload_warning      = torque >= ol_level;
    nxt_st.stored_sequence_busy  = seq.seq_running;
    nxt_st.delay_wait_busy       = seq.drive_delay | seq.dwell;
    nxt_st.direct_buffer_writing = seq.buf_writing;
    nxt_st.direct_ready          = ready_now;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign status = st_ff;

  // arms every-cycle checks once the first edge out of reset has passed
  logic        chk_arm_ff, nxt_chk_arm;
  logic        chk_move;
  logic [7:0]  chk_hit;

  // arm flag next value
  always_comb
  begin
    nxt_chk_arm = 1'b1;
  end

  // arm flag register, low for the first edge after reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      chk_arm_ff <= 1'b0;
    else
      chk_arm_ff <= nxt_chk_arm;
  end

  // data-number moves and done-flag hits per bit
  assign chk_move = (seq.op_start & seq.uses_data) | seq.data_switch;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      chk_hit[i] = seq.data_complete && seq.complete_no == sel[i];
  end

  // checks
  sequence start_no_home_s;
    seq.op_start && !(seq.hs_home_done || seq.home_done || seq.preset_done);
  endsequence
  sequence data_start_s;
    seq.op_start && seq.uses_data && !seq.data_switch;
  endsequence

  home_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    (seq.hs_home_done || seq.home_done || seq.preset_done) |=> status.homing_done)
    else $error("homing flag not set after completion");
  home_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    start_no_home_s |=> !status.homing_done)
    else $error("homing flag not cleared at start");
  toggle_flip_a: assert property (@(posedge clk) disable iff (!arst_n)
    data_start_s |=> status.data_number_toggle != $past(status.data_number_toggle))
    else $error("toggle did not invert");
  act_num_a: assert property (@(posedge clk) disable iff (!arst_n)
    data_start_s |=> status.active_data_number == $past(seq.data_no))
    else $error("active number wrong");
  act_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (seq.op_start && !seq.uses_data && !seq.data_switch) |=> $stable(status.active_data_number))
    else $error("active number changed without data");
  done_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (seq.op_start && !seq.data_complete) |=> status.data_done_flags == 8'h00)
    else $error("done flags not cleared");
  zv_cmp_a: assert property (@(posedge clk) disable iff (!arst_n)
    chk_arm_ff |=> status.zero_speed == ($past(spd_mag) <= {8'h00, $past(zv_range_ff)}))
    else $error("zero speed mismatch");
  zv_max_a: assert property (@(posedge clk) disable iff (!arst_n)
    zv_range_ff <= `DSO_ZV_RANGE_MAX)
    else $error("zero speed range above limit");
  ol_cmp_a: assert property (@(posedge clk) disable iff (!arst_n)
    (torque >= ol_level) |=> status.overload_warning)
    else $error("overload warning missing");
  busy_track_a: assert property (@(posedge clk) disable iff (!arst_n)
    seq.seq_running [*2] |-> ##1 status.stored_sequence_busy && $past(status.stored_sequence_busy))
    else $error("sequence busy dropped");
  delay_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    (seq.drive_delay || seq.dwell) |=> status.delay_wait_busy)
    else $error("delay busy missing");
  buf_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    seq.buf_writing |=> status.direct_buffer_writing)
    else $error("buffer writing missing");
  ready_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdy_in.tool_busy || rdy_in.net_busy) [*3] |=> !status.direct_ready)
    else $error("ready while tool or network busy");
  ready_cond_a: assert property (@(posedge clk) disable iff (!arst_n)
    status.direct_ready |-> $past(rdy_s2_ff.servo_on_input) && !$past(rdy_s2_ff.alarm))
    else $error("ready without servo on or with alarm");

  // homing flag holds without event or start
  home_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!seq.op_start && !(seq.hs_home_done || seq.home_done || seq.preset_done))
    |=> $stable(status.homing_done))
    else $error("homing flag moved without cause");
  // toggle inverts on switch mid-operation
  toggle_switch_a: assert property (@(posedge clk) disable iff (!arst_n)
    seq.data_switch |=> status.data_number_toggle != $past(status.data_number_toggle))
    else $error("toggle did not invert on switch");
  // toggle still outside data moves
  toggle_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !chk_move |=> $stable(status.data_number_toggle))
    else $error("toggle moved without data change");
  // active number follows a switch
  act_switch_a: assert property (@(posedge clk) disable iff (!arst_n)
    seq.data_switch |=> status.active_data_number == $past(seq.data_no))
    else $error("active number wrong after switch");
  // active number still outside data moves
  act_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !chk_move |=> $stable(status.active_data_number))
    else $error("active number moved without data change");

  // selected completion sets its bit
  done_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    (chk_hit != 8'h00) |=> (status.data_done_flags & $past(chk_hit)) == $past(chk_hit))
    else $error("done flag not set on completion");
  // done flags hold without start or hit
  done_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!seq.op_start && chk_hit == 8'h00) |=> $stable(status.data_done_flags))
    else $error("done flags moved without cause");
  // select registers take written words
  sel_lo_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_pend_ff && wr_addr_ff == `DSO_ADDR_SEL_LO) |=> sel_lo_ff == $past(hwdata))
    else $error("low selects not written");
  sel_hi_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_pend_ff && wr_addr_ff == `DSO_ADDR_SEL_HI) |=> sel_hi_ff == $past(hwdata))
    else $error("high selects not written");
  // selects hold without a write
  sel_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_pend_ff |=> $stable(sel_lo_ff) && $stable(sel_hi_ff))
    else $error("selects moved without write");

  // range takes legal writes, clamps large ones
  zv_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_pend_ff && wr_addr_ff == `DSO_ADDR_ZV_RANGE && hwdata[7:0] <= `DSO_ZV_RANGE_MAX)
    |=> zv_range_ff == $past(hwdata[7:0]))
    else $error("zero speed range not written");
  zv_clamp_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_pend_ff && wr_addr_ff == `DSO_ADDR_ZV_RANGE && hwdata[7:0] > `DSO_ZV_RANGE_MAX)
    |=> zv_range_ff == `DSO_ZV_RANGE_MAX)
    else $error("zero speed range not clamped");
  // warning off below the level
  ol_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
    (torque < ol_level) |=> !status.overload_warning)
    else $error("overload warning below level");
  // busy flags drop with their causes
  busy_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
    !seq.seq_running |=> !status.stored_sequence_busy)
    else $error("sequence busy without operation");
  delay_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !(seq.drive_delay || seq.dwell) |=> !status.delay_wait_busy)
    else $error("delay busy without delay or dwell");
  buf_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    !seq.buf_writing |=> !status.direct_buffer_writing)
    else $error("buffer writing without write");

  // ready follows the synchronised conditions
  ready_ok_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdy_s2_ff == 11'h700) |=> status.direct_ready)
    else $error("ready missing with all conditions met");
  ready_stop_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rdy_s2_ff.stop_input || rdy_s2_ff.alarm) |=> !status.direct_ready)
    else $error("ready with stop or alarm");
  // outputs still inactive on the first edge after reset
  rst_exit_a: assert property (@(posedge clk) disable iff (!arst_n)
    !chk_arm_ff |-> status == '0 && !hreadyout)
    else $error("outputs active right after reset");
  // status read returns the registered flags
  rd_status_a: assert property (@(posedge clk) disable iff (!arst_n)
    (addr_ph && !hwrite && haddr == `DSO_ADDR_STATUS) |=> hrdata == {8'h00, $past(status)})
    else $error("status read data wrong");
endmodule

/* tb/dso_host_model.sv */
`timescale 1ns/1ns
// ahb-lite master standing in for the host controller
module dso_host_model
(
  input  wire logic        clk,            // control clock
  input  wire logic        hready,         // bus ready
  input  wire logic [31:0] hrdata,         // read data
  output logic             hsel   = 1'b0,  // select
  output logic [7:0]       haddr  = 8'h00, // address
  output logic [1:0]       htrans = 2'h0,  // transfer type
  output logic             hwrite = 1'b0,  // write
  output logic [2:0]       hsize  = 3'h2,  // always a word
  output logic [31:0]      hwdata = 32'h0  // write data
);
  // one single transfer, each phase held until hready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    // a read leaves the data lines moving, never a stale value
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
module tb;
  import dso_pkg::*;
  localparam dso_ready_t RDY_OK = 11'h700;
  localparam int KS[12] = '{4, 0, 3, 2, 3, 3, 5, 1, 6, 0, 3, 7};
  localparam int NS[12] = '{0, 3, 3, 5, 5, 4, 0, 9, 0, 200, 200, 0};
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  dso_seq_t           seq = '0;
  dso_ready_t         rdy_in = '0;
  logic signed [15:0] fb_speed = '0;
  logic [15:0]        torque = '0;
  logic [15:0]        ol_level = 16'h03E8;
  logic               hsel, hwrite, hreadyout, hresp;
  logic [7:0]         haddr;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        hwdata, hrdata, q, e_word;
  dso_status_t        status;
  logic [7:0]         sel [8];
  logic [7:0]         e_act = '0, e_done = '0, zv = 8'h0F;
  logic               e_home = 1'b0, e_tog = 1'b0, e_rdy = 1'b0;
  int                 num_errors = 0, checks_done = 0, seed = 6817;

  // 20 MHz clock
  always #25 clk = ~clk;

  dso_status uut (.clk(clk), .arst_n(arst_n), .seq(seq), .rdy_in(rdy_in),
    .fb_speed(fb_speed), .torque(torque), .ol_level(ol_level), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .status(status));

  dso_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  // compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    host.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  // readiness pins pass a synchroniser, so allow it to settle
  task set_rdy(input dso_ready_t r);
    @(posedge clk);
    rdy_in <= r;
    repeat (4) @(posedge clk);
    #1;
    e_rdy = (r == RDY_OK);
    chk("direct_ready", 32'(e_rdy), 32'(status.direct_ready));
  endtask

  // one sequencer event with random levels, speed and torque
  task ev(input int k, input logic [7:0] n);
    dso_seq_t s;
    int       spd;
    s = '0;
    {s.seq_running, s.drive_delay, s.dwell, s.buf_writing} = 4'($random(seed));
    spd = $random(seed) % (int'(zv) + 8);
    s.op_start = (k < 2);
    s.uses_data = (k == 0);
    s.data_switch = (k == 2);
    s.data_complete = (k == 3);
    s.hs_home_done = (k == 4);
    s.home_done = (k == 5);
    s.preset_done = (k == 6);
    s.data_no = n;
    s.complete_no = n;
    @(posedge clk);
    seq <= s;
    fb_speed <= 16'(spd);
    torque <= 16'(999 + $random(seed) % 3);
    @(posedge clk);
    {s.op_start, s.data_switch, s.data_complete} = '0;
    {s.hs_home_done, s.home_done, s.preset_done} = '0;
    seq <= s;
    if (k < 2) e_done = '0;
    if (k < 2) e_home = 1'b0;
    if (k == 0 || k == 2) e_tog = ~e_tog;
    if (k == 0 || k == 2) e_act = n;
    for (int i = 0; i < 8; i++) if (k == 3 && sel[i] == n) e_done[i] = 1'b1;
    if (k >= 4 && k <= 6) e_home = 1'b1;
    #1;
    e_word = {8'h0, e_done, e_act, e_rdy, s.buf_writing, s.drive_delay | s.dwell,
              s.seq_running, torque >= ol_level, (spd < 0 ? -spd : spd) <= int'(zv),
              e_tog, e_home};
    chk("status", e_word, 32'(status));
  endtask

  task finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test;
  end

  // main sequence
  initial
  begin
    for (int i = 0; i < 8; i++) sel[i] = 8'(i);
    repeat (4) @(posedge clk);
    #1 chk("reset outputs", 32'h0, 32'({hreadyout, status}));
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("hresp", 32'h0, 32'(hresp));
    rd(8'h00, 32'h0F, "zv range");
    rd(8'h04, 32'h03020100, "select lo");
    rd(8'h08, 32'h07060504, "select hi");
    rd(8'h10, 32'h0, "unmapped");
    host.xfer(1'b1, 8'h00, 32'h000000FA, q);
    zv = 8'hC8;
    rd(8'h00, 32'hC8, "zv clamp");
    host.xfer(1'b1, 8'h04, 32'h030201C8, q);
    sel[0] = 8'hC8;
    set_rdy(RDY_OK);
    for (int i = 0; i < 11; i++) set_rdy(RDY_OK ^ 11'(1 << i));
    set_rdy(RDY_OK);
    for (int r = 0; r < 3; r++)
    begin
      if (r == 1) host.xfer(1'b1, 8'h00, 32'h0000000F, q);
      if (r == 1) zv = 8'h0F;
      for (int j = 0; j < 12; j++) ev(KS[j], 8'(NS[j]));
      rd(8'h0C, e_word, "status word");
    end
    finish_test;
  end
endmodule
